// [src/pmf_regs.svh]
`ifndef PMF_REGS_SVH
`define PMF_REGS_SVH

// Program counter and vectors (byte addresses)
`define PMF_PC_W 21
`define PMF_RESET_VEC 21'h000000
`define PMF_VEC_HI 21'h000008
`define PMF_VEC_LO 21'h000018
`define PMF_PC_STEP 21'h000002

// Second word of a two-word instruction
`define PMF_SECOND_TAG 4'hf
`define PMF_LIT_W 12

// Table pointer update modes
`define PMF_TBL_HOLD 2'h0
`define PMF_TBL_POSTINC 2'h1
`define PMF_TBL_POSTDEC 2'h2
`define PMF_TBL_STEP 21'h000001

`endif

// [src/pmf_pkg.sv]
package pmf_pkg;
  typedef logic [20:0] pmf_addr_t;
  typedef logic [15:0] pmf_word_t;
  typedef logic [1:0] pmf_mode_t;

  // Fetch sequencer states
  typedef enum logic {
    SEQ_IDLE,
    SEQ_WAIT_SECOND
  } pmf_seq_e;

  // First words that need a second literal word
  function automatic logic pmf_is_two_word(input pmf_word_t w);
    logic r;
    r = 1'h0;
    if (w[15:12] == 4'hc) r = 1'h1;
    if (w[15:9] == 7'h76) r = 1'h1;
    if (w[15:8] == 8'hef) r = 1'h1;
    if (w[15:6] == 10'h3b8) r = 1'h1;
    return r;
  endfunction

  // Zero fill above the implemented array
  function automatic pmf_word_t pmf_fill(input pmf_addr_t a, input pmf_word_t w,
                                         input int unsigned mem_bytes);
    return (32'(a) >= mem_bytes) ? 16'h0000 : w;
  endfunction
endpackage

// [src/pmf_word_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmf_regs.svh"
module pmf_word_decode #(
  parameter int unsigned MEM_BYTES = 65536
) (
  // Fetched word
  input wire pmf_pkg::pmf_addr_t addr_i,
  input wire pmf_pkg::pmf_word_t raw_i,
  // Classification
  output pmf_pkg::pmf_word_t word_o,
  output logic second_o,
  output logic two_word_o
);
  import pmf_pkg::*;

  // Unimplemented space reads zero, which decodes as a no-op
  always_comb begin
    word_o = pmf_fill(addr_i, raw_i, MEM_BYTES); // [RULE1]
    second_o = (word_o[15:12] == `PMF_SECOND_TAG); // [RULE7]
    two_word_o = pmf_is_two_word(word_o); // [RULE7]
  end
endmodule // pmf_word_decode
`default_nettype wire

// [src/pmf_table_read.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmf_regs.svh"
module pmf_table_read #(
  parameter int unsigned MEM_BYTES = 65536
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Core requests
  input wire logic ptr_load_i,
  input wire pmf_pkg::pmf_addr_t ptr_data_i,
  input wire logic read_i,
  input wire pmf_pkg::pmf_mode_t mode_i,
  // Flash table port
  input wire pmf_pkg::pmf_word_t word_i,
  output pmf_pkg::pmf_addr_t addr_o,
  // Results
  output logic [7:0] table_read_latch_o,
  output pmf_pkg::pmf_addr_t table_byte_pointer_o,
  output logic done_o
);
  import pmf_pkg::*;

  pmf_addr_t next_ptr;
  logic [7:0] next_latch;
  logic next_done;
  pmf_word_t filled;

  // Word address only; the byte lane is picked here
  assign addr_o = {table_byte_pointer_o[20:1], 1'h0};

  // Pointer load wins over a read in the same cycle
  always_comb begin
    filled = pmf_fill(addr_o, word_i, MEM_BYTES); // [RULE1]
    next_ptr = table_byte_pointer_o;
    next_latch = table_read_latch_o; // [RULE14]
    next_done = 1'h0;
    if (ptr_load_i) begin
      next_ptr = ptr_data_i;
    end else if (read_i) begin
      next_latch = table_byte_pointer_o[0] ? filled[15:8] : filled[7:0]; // [RULE10] [RULE12]
      next_done = 1'h1;
      case (mode_i)
        `PMF_TBL_POSTINC: next_ptr = table_byte_pointer_o + `PMF_TBL_STEP; // [RULE11]
        `PMF_TBL_POSTDEC: next_ptr = table_byte_pointer_o - `PMF_TBL_STEP; // [RULE11]
        default: next_ptr = table_byte_pointer_o;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      table_byte_pointer_o <= 21'h000000;
      table_read_latch_o <= 8'h00;
      done_o <= 1'h0;
    end else begin
      table_byte_pointer_o <= next_ptr;
      table_read_latch_o <= next_latch;
      done_o <= next_done;
    end
  end

  property p_tbl_byte;
    @(posedge clk_i) disable iff (!rst_n_i)
      (read_i && !ptr_load_i) |=> table_read_latch_o ==
        ($past(table_byte_pointer_o[0]) ? $past(filled[15:8]) : $past(filled[7:0]));
  endproperty
  a_tbl_byte: assert property (p_tbl_byte) else $error("table latch wrong byte"); // [RULE12]

  property p_tbl_inc;
    @(posedge clk_i) disable iff (!rst_n_i)
      (read_i && !ptr_load_i && mode_i == `PMF_TBL_POSTINC)
        |=> table_byte_pointer_o == $past(table_byte_pointer_o) + 21'h000001;
  endproperty
  a_tbl_inc: assert property (p_tbl_inc) else $error("pointer not incremented"); // [RULE11]

  property p_tbl_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !read_i || ptr_load_i |=> $stable(table_read_latch_o) && !done_o;
  endproperty
  a_tbl_hold: assert property (p_tbl_hold) else $error("latch changed without read"); // [RULE14]

  c_tbl_inc: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    read_i && !ptr_load_i && mode_i == `PMF_TBL_POSTINC ##1 read_i);
endmodule // pmf_table_read
`default_nettype wire

// [src/pmf_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmf_regs.svh"
// Notes on behaviour
// RULE1: 21-bit PC; unimplemented space reads zero
// RULE2: Reset at 0000h, vectors 0008h, 0018h
// RULE3: Instruction low byte at even address
// RULE4: PC steps by two, bit 0 zero
// RULE5: Absolute jump loads word into PC[20:1]
// RULE6: Relative offset counts words, doubled
// RULE7: Second words tagged 1111 plus 12-bit literal
// RULE8: In-sequence second word supplies the literal
// RULE9: Lone tagged word executes as no-op
// RULE10: Table read fetches one byte into latch
// RULE11: Table pointer optionally auto-updated
// RULE12: Pointer bit 0 selects low/high byte
// RULE13: Fetch and table/data access run concurrently
// RULE14: Latch holds until next table read
module pmf_core #(
  parameter int unsigned MEM_BYTES = 65536
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Flow control from the core
  input wire logic advance_i,
  input wire logic skip_i,
  input wire logic irq_hi_i,
  input wire logic irq_lo_i,
  input wire logic jump_i,
  input wire logic [19:0] jump_word_i,
  input wire logic branch_i,
  input wire logic [10:0] branch_off_i,
  // Table read requests
  input wire logic tbl_ptr_load_i,
  input wire pmf_pkg::pmf_addr_t tbl_ptr_data_i,
  input wire logic table_read_instr_i,
  input wire pmf_pkg::pmf_mode_t tbl_mode_i,
  // Flash array ports
  input wire pmf_pkg::pmf_word_t fetch_word_i,
  input wire pmf_pkg::pmf_word_t tbl_word_i,
  output pmf_pkg::pmf_addr_t fetch_addr_o,
  output pmf_pkg::pmf_addr_t tbl_addr_o,
  // Issued instruction
  output logic instr_valid_o,
  output pmf_pkg::pmf_word_t instr_word_o,
  output logic [11:0] instr_literal_o,
  output logic instr_two_word_o,
  output logic instr_nop_o,
  // Table read results
  output logic [7:0] table_read_latch_o,
  output pmf_pkg::pmf_addr_t table_byte_pointer_o,
  output logic tbl_done_o
);
  import pmf_pkg::*;

  // Sequencer state
  pmf_addr_t pc;
  pmf_seq_e seq;
  pmf_word_t first;
  pmf_addr_t next_pc;
  pmf_seq_e next_seq;
  pmf_word_t next_first;
  logic next_valid;
  pmf_word_t next_word;
  logic [11:0] next_lit;
  logic next_two;
  logic next_nop;
  logic redirect;

  // Decoded fetch word
  pmf_word_t dec_word;
  logic dec_second;
  logic dec_two;

  // The PC is the flash fetch address; its low byte lane is even
  assign fetch_addr_o = pc; // [RULE3]

  pmf_word_decode #(
    .MEM_BYTES(MEM_BYTES)
  ) u_decode (
    .addr_i(pc),
    .raw_i(fetch_word_i),
    .word_o(dec_word),
    .second_o(dec_second),
    .two_word_o(dec_two)
  );

  // Table port is separate, so it never stalls fetch
  pmf_table_read #(
    .MEM_BYTES(MEM_BYTES)
  ) u_table ( // [RULE13]
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ptr_load_i(tbl_ptr_load_i),
    .ptr_data_i(tbl_ptr_data_i),
    .read_i(table_read_instr_i),
    .mode_i(tbl_mode_i),
    .word_i(tbl_word_i),
    .addr_o(tbl_addr_o),
    .table_read_latch_o(table_read_latch_o),
    .table_byte_pointer_o(table_byte_pointer_o),
    .done_o(tbl_done_o)
  );

  assign redirect = irq_hi_i | irq_lo_i | jump_i | branch_i;

  // Next PC and issue; redirects drop any half-fetched pair
  always_comb begin
    next_pc = pc;
    next_seq = seq;
    next_first = first;
    next_valid = 1'h0;
    next_word = instr_word_o;
    next_lit = instr_literal_o;
    next_two = 1'h0;
    next_nop = 1'h0;
    if (irq_hi_i) begin
      next_pc = `PMF_VEC_HI; // [RULE2]
      next_seq = SEQ_IDLE;
    end else if (irq_lo_i) begin
      next_pc = `PMF_VEC_LO; // [RULE2]
      next_seq = SEQ_IDLE;
    end else if (jump_i) begin
      next_pc = {jump_word_i, 1'h0}; // [RULE5]
      next_seq = SEQ_IDLE;
    end else if (branch_i) begin
      next_pc = pc + {{9{branch_off_i[10]}}, branch_off_i, 1'h0}; // [RULE6]
      next_seq = SEQ_IDLE;
    end else if (advance_i) begin
      next_pc = pc + `PMF_PC_STEP; // [RULE4]
      case (seq)
        SEQ_IDLE: begin
          if (skip_i) begin
            next_seq = SEQ_IDLE;
          end else if (dec_second) begin
            // Tagged word alone: no-op, literal ignored
            next_valid = 1'h1; // [RULE9]
            next_word = dec_word;
            next_nop = 1'h1;
          end else if (dec_two) begin
            next_first = dec_word;
            next_seq = SEQ_WAIT_SECOND;
          end else begin
            next_valid = 1'h1;
            next_word = dec_word;
            next_nop = (dec_word == 16'h0000);
          end
        end
        SEQ_WAIT_SECOND: begin
          next_seq = SEQ_IDLE;
          if (skip_i) begin
            next_seq = SEQ_IDLE;
          end else if (dec_second) begin
            next_valid = 1'h1; // [RULE8]
            next_word = first;
            next_lit = dec_word[11:0];
            next_two = 1'h1;
          end else begin
            // Malformed pair: retire the first word harmlessly
            next_valid = 1'h1;
            next_word = first;
            next_nop = 1'h1;
          end
        end
        default: next_seq = SEQ_IDLE;
      endcase
    end
    next_pc[0] = 1'h0; // [RULE4]
  end

  // Registers; reset enters at the reset vector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc <= `PMF_RESET_VEC; // [RULE2]
      seq <= SEQ_IDLE;
      first <= 16'h0000;
      instr_valid_o <= 1'h0;
      instr_word_o <= 16'h0000;
      instr_literal_o <= 12'h000;
      instr_two_word_o <= 1'h0;
      instr_nop_o <= 1'h0;
    end else begin
      pc <= next_pc;
      seq <= next_seq;
      first <= next_first;
      instr_valid_o <= next_valid;
      instr_word_o <= next_word;
      instr_literal_o <= next_lit;
      instr_two_word_o <= next_two;
      instr_nop_o <= next_nop;
    end
  end

  // Checks on the fetch sequencer
  property p_reset_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> fetch_addr_o == 21'h000000;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong"); // [RULE2]

  property p_irq_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_hi_i |=> fetch_addr_o == 21'h000008;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("high vector wrong"); // [RULE2]

  property p_irq_lo_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
      (irq_lo_i && !irq_hi_i) |=> fetch_addr_o == 21'h000018 && !instr_valid_o;
  endproperty
  a_irq_lo_vec: assert property (p_irq_lo_vec) else $error("low vector wrong"); // [RULE2]

  property p_step;
    @(posedge clk_i) disable iff (!rst_n_i)
      (advance_i && !redirect) |=> fetch_addr_o == $past(fetch_addr_o) + 21'h000002
        && fetch_addr_o[0] == 1'h0;
  endproperty
  a_step: assert property (p_step) else $error("pc step wrong"); // [RULE4]

  property p_jump;
    @(posedge clk_i) disable iff (!rst_n_i)
      (jump_i && !irq_hi_i && !irq_lo_i) |=> fetch_addr_o == {$past(jump_word_i), 1'h0};
  endproperty
  a_jump: assert property (p_jump) else $error("absolute target wrong"); // [RULE5]

  property p_branch;
    @(posedge clk_i) disable iff (!rst_n_i)
      (branch_i && !jump_i && !irq_hi_i && !irq_lo_i) |=> fetch_addr_o ==
        $past(fetch_addr_o) + {{9{$past(branch_off_i[10])}}, $past(branch_off_i), 1'h0};
  endproperty
  a_branch: assert property (p_branch) else $error("relative target wrong"); // [RULE6]

  property p_pair;
    @(posedge clk_i) disable iff (!rst_n_i)
      (seq == SEQ_WAIT_SECOND && advance_i && !skip_i && !redirect && dec_second)
        |=> instr_valid_o && instr_two_word_o && !instr_nop_o
          && instr_literal_o == $past(dec_word[11:0]);
  endproperty
  a_pair: assert property (p_pair) else $error("second word literal lost"); // [RULE8]

  property p_lone;
    @(posedge clk_i) disable iff (!rst_n_i)
      (seq == SEQ_IDLE && advance_i && !skip_i && !redirect && dec_second)
        |=> instr_valid_o && instr_nop_o && !instr_two_word_o;
  endproperty
  a_lone: assert property (p_lone) else $error("lone second word not a no-op"); // [RULE9]

  property p_zero_fill;
    @(posedge clk_i) disable iff (!rst_n_i)
      (32'(fetch_addr_o) >= MEM_BYTES) |-> dec_word == 16'h0000;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("unimplemented read not zero"); // [RULE1]

  property p_skip;
    @(posedge clk_i) disable iff (!rst_n_i)
      (advance_i && skip_i && !redirect) |=> !instr_valid_o && seq == SEQ_IDLE;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped word issued"); // [RULE9]

  property p_concurrent;
    @(posedge clk_i) disable iff (!rst_n_i)
      (advance_i && !redirect && table_read_instr_i && !tbl_ptr_load_i)
        |=> tbl_done_o && fetch_addr_o == $past(fetch_addr_o) + 21'h000002;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("table read stalled fetch"); // [RULE13]

  property p_first_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      (seq == SEQ_IDLE && advance_i && !skip_i && !redirect && dec_two && !dec_second)
        |=> !instr_valid_o && seq == SEQ_WAIT_SECOND;
  endproperty
  a_first_held: assert property (p_first_held) else $error("pair start wrong"); // [RULE8]

  // A first word without its tagged partner must not borrow a literal
  property p_broken_pair;
    @(posedge clk_i) disable iff (!rst_n_i)
      (seq == SEQ_WAIT_SECOND && advance_i && !skip_i && !redirect && !dec_second)
        |=> instr_valid_o && instr_nop_o && !instr_two_word_o && instr_word_o == $past(first);
  endproperty
  a_broken_pair: assert property (p_broken_pair) else $error("broken pair wrong"); // [RULE8]

  property p_redir_drop;
    @(posedge clk_i) disable iff (!rst_n_i)
      redirect |=> !instr_valid_o && seq == SEQ_IDLE;
  endproperty
  a_redir_drop: assert property (p_redir_drop) else $error("redirect kept word"); // [RULE5]

  property p_aligned;
    @(posedge clk_i) disable iff (!rst_n_i)
      fetch_addr_o[0] == 1'h0;
  endproperty
  a_aligned: assert property (p_aligned) else $error("fetch address odd"); // [RULE3]

  property p_zero_nop;
    @(posedge clk_i) disable iff (!rst_n_i)
      (seq == SEQ_IDLE && advance_i && !skip_i && !redirect && dec_word == 16'h0000)
        |=> instr_valid_o && instr_nop_o;
  endproperty
  a_zero_nop: assert property (p_zero_nop) else $error("zero word not a no-op"); // [RULE1]

  // Main scenarios
  c_pair: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    instr_valid_o && instr_two_word_o);
  c_lone: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    advance_i && skip_i ##1 advance_i ##1 instr_nop_o);
  c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_lo_i ##1 fetch_addr_o == 21'h000018);
  c_branch_back: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    branch_i && branch_off_i[10]);
endmodule // pmf_core
`default_nettype wire

// [tb/pmf_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmf_flash_model #(
  parameter int unsigned WORDS = 256
) (
  // Byte addresses from the block
  input wire pmf_pkg::pmf_addr_t fetch_addr_i,
  input wire pmf_pkg::pmf_addr_t tbl_addr_i,
  // Words back, same cycle
  output pmf_pkg::pmf_word_t fetch_word_o,
  output pmf_pkg::pmf_word_t tbl_word_o
);
  import pmf_pkg::*;

  pmf_word_t mem [WORDS];

  // Word-organised array: byte address bit 0 never picks a word
  function automatic pmf_word_t rd(input pmf_addr_t a);
    // Unbacked space shows a moving pattern, so zero fill must come from the block
    if (32'(a[20:1]) >= WORDS) return a[15:0] ^ 16'h5a5a;
    return mem[32'(a[20:1])];
  endfunction

  // Two independent read ports, fetch and table at once
  always_comb begin
    fetch_word_o = rd(fetch_addr_i);
    tbl_word_o = rd(tbl_addr_i);
  end
endmodule // pmf_flash_model
`default_nettype wire

// [tb/program_memory_fetch_addressing_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module program_memory_fetch_addressing_bench;
  import pmf_pkg::*;

  // Small array so the zero-filled space is cheap to reach
  localparam int unsigned MEM = 512;
  // Strobe masks, in the order of the step task's concatenation
  localparam logic [7:0] S_ADV = 8'h80;
  localparam logic [7:0] S_SKIP = 8'h40;
  localparam logic [7:0] S_IRQ_HI = 8'h20;
  localparam logic [7:0] S_IRQ_LO = 8'h10;
  localparam logic [7:0] S_JMP = 8'h08;
  localparam logic [7:0] S_BR = 8'h04;
  localparam logic [7:0] S_LD = 8'h02;
  localparam logic [7:0] S_RD = 8'h01;

  // Stimulus
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic adv = 1'h0;
  logic skip = 1'h0;
  logic irq_hi = 1'h0;
  logic irq_lo = 1'h0;
  logic jmp = 1'h0;
  logic [19:0] jword = 20'h00000;
  logic br = 1'h0;
  logic [10:0] boff = 11'h000;
  logic ld = 1'h0;
  pmf_addr_t pdata = 21'h000000;
  logic rd = 1'h0;
  pmf_mode_t mode = 2'h0;
  // Observed
  pmf_word_t fword;
  pmf_word_t tword;
  pmf_addr_t faddr;
  pmf_addr_t taddr;
  logic valid;
  pmf_word_t iword;
  logic [11:0] lit;
  logic two;
  logic nop;
  logic [7:0] latch;
  pmf_addr_t ptr;
  logic done;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  pmf_core #(.MEM_BYTES(MEM)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .advance_i(adv), .skip_i(skip),
    .irq_hi_i(irq_hi), .irq_lo_i(irq_lo), .jump_i(jmp), .jump_word_i(jword),
    .branch_i(br), .branch_off_i(boff), .tbl_ptr_load_i(ld), .tbl_ptr_data_i(pdata),
    .table_read_instr_i(rd), .tbl_mode_i(mode), .fetch_word_i(fword),
    .tbl_word_i(tword), .fetch_addr_o(faddr), .tbl_addr_o(taddr),
    .instr_valid_o(valid), .instr_word_o(iword), .instr_literal_o(lit),
    .instr_two_word_o(two), .instr_nop_o(nop), .table_read_latch_o(latch),
    .table_byte_pointer_o(ptr), .tbl_done_o(done));

  pmf_flash_model #(.WORDS(MEM / 2)) u_flash (
    .fetch_addr_i(faddr), .tbl_addr_i(taddr), .fetch_word_o(fword), .tbl_word_o(tword));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One cycle: strobes set once at a fall, taken at the next rise
  task automatic step(input logic [7:0] s);
    {adv, skip, irq_hi, irq_lo, jmp, br, ld, rd} = s;
    @(negedge clk);
  endtask

  task automatic t_flow();
    chk(faddr, 32'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'h0e55);
    chk(nop, 1'h0);
    chk(faddr, 32'h2);
    step(S_ADV);
    chk(valid, 1'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'hc123);
    chk(lit, 12'h456);
    chk(two, 1'h1);
    chk(faddr, 32'h6);
    // Skip the first word so its tagged partner runs alone
    step(S_ADV | S_SKIP);
    chk(valid, 1'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(nop, 1'h1);
    chk(two, 1'h0);
    chk(iword, 16'hf0ab);
    chk(faddr, 32'ha);
  endtask

  // Jump and call pairs, a broken pointer-load pair, pairs cut by an interrupt or a skip
  task automatic t_pairs();
    step(S_ADV);
    chk(valid, 1'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'hef03);
    chk(lit, 12'h000);
    chk(two, 1'h1);
    step(S_ADV);
    step(S_ADV);
    chk(iword, 16'hec12);
    chk(lit, 12'h345);
    chk(two, 1'h1);
    step(S_ADV);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'hee12);
    chk(nop, 1'h1);
    chk(two, 1'h0);
    chk(lit, 12'h345);
    step(S_ADV);
    step(S_IRQ_LO);
    chk(faddr, 32'h18);
    chk(valid, 1'h0);
    step(S_ADV);
    chk(nop, 1'h1);
    chk(two, 1'h0);
    chk(iword, 16'hf222);
    step(S_ADV);
    step(S_ADV | S_SKIP);
    chk(valid, 1'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'h2400);
    chk(two, 1'h0);
    chk(faddr, 32'h20);
  endtask

  task automatic t_redirect();
    jword = 20'h00040;
    step(S_IRQ_HI | S_JMP);
    chk(faddr, 32'h8);
    step(S_IRQ_LO);
    chk(faddr, 32'h18);
    jword = 20'h00003;
    step(S_JMP);
    chk(faddr, 32'h6);
    boff = 11'h7ff;
    step(S_BR);
    chk(faddr, 32'h4);
    chk(valid, 1'h0);
    // Redirect beats a same-cycle advance
    boff = 11'h003;
    step(S_BR | S_ADV);
    chk(faddr, 32'ha);
    chk(valid, 1'h0);
    jword = 20'h80001;
    step(S_JMP);
    chk(faddr, 32'h100002);
    // Far above the array: words come back zero and run as no-ops
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'h0000);
    chk(nop, 1'h1);
    chk(faddr, 32'h100004);
  endtask

  task automatic t_table();
    pdata = 21'h000002;
    step(S_LD);
    chk(ptr, 32'h2);
    chk(taddr, 32'h2);
    mode = 2'h1;
    step(S_RD);
    chk(done, 1'h1);
    chk(latch, 8'h23);
    chk(ptr, 32'h3);
    step(S_RD);
    chk(latch, 8'hc1);
    chk(ptr, 32'h4);
    // Table read alongside an instruction fetch
    mode = 2'h2;
    step(S_RD | S_ADV);
    chk(latch, 8'h56);
    chk(ptr, 32'h3);
    chk(valid, 1'h1);
    chk(faddr, 32'h100006);
    mode = 2'h3;
    step(S_RD);
    chk(latch, 8'hc1);
    chk(ptr, 32'h3);
    repeat (3) step(8'h00);
    chk(latch, 8'hc1);
    chk(done, 1'h0);
    // Load wins over a same-cycle read
    pdata = 21'h000400;
    step(S_LD | S_RD);
    chk(done, 1'h0);
    chk(latch, 8'hc1);
    mode = 2'h0;
    step(S_RD);
    chk(done, 1'h1);
    chk(latch, 8'h00);
    chk(ptr, 32'h400);
  endtask

  // Reset in mid-run clears pointer and latch and restarts at the vector
  task automatic t_reset();
    pdata = 21'h000003;
    step(S_LD);
    mode = 2'h1;
    step(S_RD);
    chk(latch, 8'hc1);
    rst_n = 1'h0;
    repeat (2) step(8'h00);
    rst_n = 1'h1;
    chk(faddr, 32'h0);
    chk(ptr, 32'h0);
    chk(taddr, 32'h0);
    chk(latch, 8'h00);
    chk(valid, 1'h0);
    chk(done, 1'h0);
    step(S_ADV);
    chk(valid, 1'h1);
    chk(iword, 16'h0e55);
    chk(faddr, 32'h2);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    for (int i = 0; i < MEM / 2; i++) u_flash.mem[i] = 16'h2400;
    u_flash.mem[0] = 16'h0e55;
    u_flash.mem[1] = 16'hc123;
    u_flash.mem[2] = 16'hf456;
    u_flash.mem[3] = 16'hc789;
    u_flash.mem[4] = 16'hf0ab;
    // Jump and call pairs, a pointer-load word with no tagged partner, then pairs cut short
    u_flash.mem[5] = 16'hef03;
    u_flash.mem[6] = 16'hf000;
    u_flash.mem[7] = 16'hec12;
    u_flash.mem[8] = 16'hf345;
    u_flash.mem[9] = 16'hee12;
    u_flash.mem[11] = 16'hc111;
    u_flash.mem[12] = 16'hf222;
    u_flash.mem[13] = 16'hc333;
    u_flash.mem[14] = 16'hf444;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk(ptr, 32'h0);
    chk(latch, 8'h00);
    t_flow();
    t_pairs();
    t_redirect();
    t_table();
    t_reset();
    print_verdict();
  end
endmodule // program_memory_fetch_addressing_bench
`default_nettype wire
